// ---- hw/cim_mask_logic.sv ----
// Charger interrupt mask registers, event flags and interrupt pulse.
// What this block does
// - Conversion-done mask bit 6 clear lets one-shot conversion completion pulse interrupt.
// - Bit 5 clear lets entering thermal regulation interrupt; set blocks it.
// - Bit 4 clear lets entering or leaving system floor regulation interrupt.
// - Bit 3 governs current, limit pin and boost current loop entry.
// - Bit 1 governs fast, trickle and pre-charge safety timer expiry.
// - Bit 0 governs watchdog expiry interrupts.
// - Second mask bit 3 governs charge status change interrupts.
// - Second mask bit 0 governs bus supply status change interrupts.
// - Fault mask bit 7 governs supply overvoltage or sleep entry.
// - Fault mask bit 6 governs battery overcurrent or overvoltage faults.
// - Fault mask bit 5 governs system overvoltage or short faults.
// - Fault mask bit 4 governs boost reverse current and voltage faults.
// - Fault mask bit 3 governs thermal shutdown interrupts.
// - Fault mask bit 0 governs temperature zone change interrupts.
// - First mask byte resets to zero.
// - Flags set on a rising edge, or on any change for floor regulation, charge/supply status and temperature zone.
// - Conversion-done flag sets only in one-shot mode on completion.
`timescale 1ns/1ps
`default_nettype none
module cim_mask_logic (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       regResetCmd,
   input  wire logic       regWrite,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       adcOneShot,
   input  wire logic       adcConvDone,
   input  wire logic       die_thermal_regulation,
   input  wire logic       system_voltage_floor,
   input  wire logic       input_current_regulation,
   input  wire logic       external_current_limit_pin,
   input  wire logic       boost_current_regulation,
   input  wire logic       input_voltage_regulation,
   input  wire logic       boost_voltage_regulation,
   input  wire logic       safetyTimerExpired,
   input  wire logic       watchdogExpired,
   input  wire logic [2:0] chargeStatus,
   input  wire logic [2:0] supplyStatus,
   input  wire logic       supplyFault,
   input  wire logic       batteryFault,
   input  wire logic       systemFault,
   input  wire logic       boostFault,
   input  wire logic       die_thermal_shutdown,
   input  wire logic [2:0] tempZone,
   input  wire logic       flagClear,
   output logic      [7:0] chargerFlagA,
   output logic      [7:0] chargerFlagB,
   output logic      [7:0] faultFlag,
   output logic            intN
);
   logic [7:0] maskA_q;
   logic [7:0] maskB_q;
   logic [7:0] maskF_q;
   logic [7:0] flagA_q;
   logic [7:0] flagB_q;
   logic [7:0] flagF_q;
   logic [7:0] rdata_q;
   logic [7:0] evA;
   logic [7:0] evB;
   logic [7:0] evF;
   logic       anyUnmasked;
   logic       adcDone_q;
   logic       die_thermal_regulation_q;
   logic       sysMin_q;
   logic       curLoop_q;
   logic       voltLoop_q;
   logic       timer_q;
   logic       wdog_q;
   logic       supF_q;
   logic       batF_q;
   logic       sysF_q;
   logic       boostF_q;
   logic       die_thermal_shutdown_q;
   logic [2:0] chg_q;
   logic [2:0] sup_q;
   logic [2:0] tz_q;
   logic       curLoop;
   logic       voltLoop;
   logic [7:0] quietCnt_q;

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   assign curLoop  = input_current_regulation | external_current_limit_pin
                   | boost_current_regulation;
   assign voltLoop = input_voltage_regulation | boost_voltage_regulation;

   // Previous event levels for edge detection.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adcDone_q  <= 1'b0;
         die_thermal_regulation_q     <= 1'b0;
         sysMin_q   <= 1'b0;
         curLoop_q  <= 1'b0;
         voltLoop_q <= 1'b0;
         timer_q    <= 1'b0;
         wdog_q     <= 1'b0;
         supF_q     <= 1'b0;
         batF_q     <= 1'b0;
         sysF_q     <= 1'b0;
         boostF_q   <= 1'b0;
         die_thermal_shutdown_q    <= 1'b0;
         chg_q      <= 3'h0;
         sup_q      <= 3'h0;
         tz_q       <= 3'h0;
      end else begin
         adcDone_q  <= adcConvDone;
         die_thermal_regulation_q     <= die_thermal_regulation;
         sysMin_q   <= system_voltage_floor;
         curLoop_q  <= curLoop;
         voltLoop_q <= voltLoop;
         timer_q    <= safetyTimerExpired;
         wdog_q     <= watchdogExpired;
         supF_q     <= supplyFault;
         batF_q     <= batteryFault;
         sysF_q     <= systemFault;
         boostF_q   <= boostFault;
         die_thermal_shutdown_q    <= die_thermal_shutdown;
         chg_q      <= chargeStatus;
         sup_q      <= supplyStatus;
         tz_q       <= tempZone;
      end
   end

   // Event strobes, one cycle each.
   always_comb begin
      evA = 8'h00;
      evB = 8'h00;
      evF = 8'h00;
      evA[cim_pkg::A_ADC_DONE]  = rise(adcConvDone, adcDone_q) & adcOneShot;
      evA[cim_pkg::A_THERM_REG] = rise(die_thermal_regulation, die_thermal_regulation_q);
      evA[cim_pkg::A_SYS_MIN]   = system_voltage_floor ^ sysMin_q;
      evA[cim_pkg::A_CUR_LOOP]  = rise(curLoop, curLoop_q);
      evA[cim_pkg::A_VOLT_LOOP] = rise(voltLoop, voltLoop_q);
      evA[cim_pkg::A_TIMER]     = rise(safetyTimerExpired, timer_q);
      evA[cim_pkg::A_WATCHDOG]  = rise(watchdogExpired, wdog_q);
      evB[cim_pkg::B_CHARGE]    = chargeStatus != chg_q;
      evB[cim_pkg::B_SUPPLY]    = supplyStatus != sup_q;
      evF[cim_pkg::F_SUPPLY]    = rise(supplyFault, supF_q);
      evF[cim_pkg::F_BATTERY]   = rise(batteryFault, batF_q);
      evF[cim_pkg::F_SYSTEM]    = rise(systemFault, sysF_q);
      evF[cim_pkg::F_BOOST]     = rise(boostFault, boostF_q);
      evF[cim_pkg::F_DIE_THERMAL_SHUTDOWN]     = rise(die_thermal_shutdown, die_thermal_shutdown_q);
      evF[cim_pkg::F_TZONE]     = tempZone != tz_q;
   end

   // Mask registers, cleared by reset and by the register-reset command.
   always_ff @(posedge core_clk) begin
      if (reset || regResetCmd) begin
         maskA_q <= cim_pkg::MASK_RESET_VAL;
         maskB_q <= cim_pkg::MASK_RESET_VAL;
         maskF_q <= cim_pkg::MASK_RESET_VAL;
      end else if (regWrite) begin
         case (regAddr)
            cim_pkg::MASK_A_ADDR: begin
               maskA_q <= regWdata;
            end
            cim_pkg::MASK_B_ADDR: begin
               maskB_q <= regWdata & cim_pkg::MASK_B_WRITABLE;
            end
            cim_pkg::FAULT_MASK_ADDR: begin
               maskF_q <= regWdata & cim_pkg::FAULT_WRITABLE;
            end
            default: begin
            end
         endcase
      end
   end

   // Flags set regardless of mask; a new event wins over a clear.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flagA_q <= 8'h00;
         flagB_q <= 8'h00;
         flagF_q <= 8'h00;
      end else if (flagClear) begin
         flagA_q <= evA;
         flagB_q <= evB;
         flagF_q <= evF;
      end else begin
         flagA_q <= flagA_q | evA;
         flagB_q <= flagB_q | evB;
         flagF_q <= flagF_q | evF;
      end
   end

   // Registered read data.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_q <= 8'h00;
      end else begin
         case (regAddr)
            cim_pkg::MASK_A_ADDR:     rdata_q <= maskA_q;
            cim_pkg::MASK_B_ADDR:     rdata_q <= maskB_q;
            cim_pkg::FAULT_MASK_ADDR: rdata_q <= maskF_q;
            default:                  rdata_q <= 8'h00;
         endcase
      end
   end

   assign anyUnmasked = |((evA & ~maskA_q) | (evB & ~maskB_q) | (evF & ~maskF_q));

   // Cycles since the last unmasked event, saturating, so the pulse checks can time it.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         quietCnt_q <= 8'hff;
      end else if (anyUnmasked) begin
         quietCnt_q <= 8'h00;
      end else if (quietCnt_q != 8'hff) begin
         quietCnt_q <= quietCnt_q + 8'h01;
      end
   end

   cim_pulse_gen uPulse (
      .core_clk (core_clk),
      .reset    (reset),
      .trigger  (anyUnmasked),
      .pulseN   (intN)
   );

   assign regRdata     = rdata_q;
   assign chargerFlagA = flagA_q;
   assign chargerFlagB = flagB_q;
   assign faultFlag    = flagF_q;

   a_masked_no_pulse: assert property (@(posedge core_clk) disable iff (reset)
      (intN && $stable(intN) && ((evA & ~maskA_q) == 8'h00) && ((evB & ~maskB_q) == 8'h00)
       && ((evF & ~maskF_q) == 8'h00)) |=> intN)
      else $error("Interrupt pulse without unmasked event.");
   a_unmasked_pulse: assert property (@(posedge core_clk) disable iff (reset)
      anyUnmasked |=> !intN [*8])
      else $error("Unmasked event gave no interrupt pulse.");
   a_flag_sets: assert property (@(posedge core_clk) disable iff (reset)
      (evA[cim_pkg::A_WATCHDOG] && !flagClear) |=> chargerFlagA[cim_pkg::A_WATCHDOG])
      else $error("Watchdog flag not set on event.");
   a_adc_oneshot: assert property (@(posedge core_clk) disable iff (reset)
      (!adcOneShot && !flagClear && !chargerFlagA[cim_pkg::A_ADC_DONE])
      |=> !chargerFlagA[cim_pkg::A_ADC_DONE])
      else $error("Conversion flag set outside one-shot mode.");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
      ((maskB_q & ~cim_pkg::MASK_B_WRITABLE) == 8'h00)
      && ((maskF_q & ~cim_pkg::FAULT_WRITABLE) == 8'h00))
      else $error("Reserved mask bit is set.");
   a_regreset_clears: assert property (@(posedge core_clk) disable iff (reset)
      regResetCmd |=> (maskA_q == 8'h00) && (maskB_q == 8'h00) && (maskF_q == 8'h00))
      else $error("Register reset left a mask set.");
   a_sysmin_exit: assert property (@(posedge core_clk) disable iff (reset)
      ($fell(system_voltage_floor) && !maskA_q[cim_pkg::A_SYS_MIN]) |=> !intN)
      else $error("Leaving floor regulation gave no pulse.");
   a_pulse_ends: assert property (@(posedge core_clk) disable iff (reset)
      (quietCnt_q >= cim_pkg::PULSE_LEN) |-> intN)
      else $error("Interrupt pulse too long.");
   a_pulse_holds: assert property (@(posedge core_clk) disable iff (reset)
      (quietCnt_q < cim_pkg::PULSE_LEN) |-> !intN)
      else $error("Interrupt pulse ended early.");
   a_adc_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(adcConvDone) && adcOneShot && !maskA_q[cim_pkg::A_ADC_DONE]) |=> !intN)
      else $error("Conversion done gave no pulse.");
   a_therm_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(die_thermal_regulation) && !maskA_q[cim_pkg::A_THERM_REG]) |=> !intN)
      else $error("Thermal regulation entry gave no pulse.");
   a_sysmin_entry: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(system_voltage_floor) && !maskA_q[cim_pkg::A_SYS_MIN]) |=> !intN)
      else $error("Entering floor regulation gave no pulse.");
   a_curloop_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(curLoop) && !maskA_q[cim_pkg::A_CUR_LOOP]) |=> !intN)
      else $error("Current loop entry gave no pulse.");
   a_voltloop_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(voltLoop) && !maskA_q[cim_pkg::A_VOLT_LOOP]) |=> !intN)
      else $error("Voltage loop entry gave no pulse.");
   a_timer_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(safetyTimerExpired) && !maskA_q[cim_pkg::A_TIMER]) |=> !intN)
      else $error("Safety timer expiry gave no pulse.");
   a_wdog_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(watchdogExpired) && !maskA_q[cim_pkg::A_WATCHDOG]) |=> !intN)
      else $error("Watchdog expiry gave no pulse.");
   a_charge_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($changed(chargeStatus) && !maskB_q[cim_pkg::B_CHARGE]) |=> !intN)
      else $error("Charge status change gave no pulse.");
   a_supply_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($changed(supplyStatus) && !maskB_q[cim_pkg::B_SUPPLY]) |=> !intN)
      else $error("Supply status change gave no pulse.");
   a_supply_fault: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(supplyFault) && !maskF_q[cim_pkg::F_SUPPLY]) |=> !intN)
      else $error("Supply fault gave no pulse.");
   a_battery_fault: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(batteryFault) && !maskF_q[cim_pkg::F_BATTERY]) |=> !intN)
      else $error("Battery fault gave no pulse.");
   a_system_fault: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(systemFault) && !maskF_q[cim_pkg::F_SYSTEM]) |=> !intN)
      else $error("System fault gave no pulse.");
   a_boost_fault: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(boostFault) && !maskF_q[cim_pkg::F_BOOST]) |=> !intN)
      else $error("Boost fault gave no pulse.");
   a_die_thermal_shutdown_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($rose(die_thermal_shutdown) && !maskF_q[cim_pkg::F_DIE_THERMAL_SHUTDOWN]) |=> !intN)
      else $error("Thermal shutdown gave no pulse.");
   a_zone_pulse: assert property (@(posedge core_clk) disable iff (reset)
      ($changed(tempZone) && !maskF_q[cim_pkg::F_TZONE]) |=> !intN)
      else $error("Temperature zone change gave no pulse.");
   a_clear_keeps: assert property (@(posedge core_clk) disable iff (reset)
      flagClear |=> (chargerFlagA == $past(evA)) && (chargerFlagB == $past(evB))
      && (faultFlag == $past(evF)))
      else $error("Flag clear lost a same-cycle event.");
endmodule : cim_mask_logic
`default_nettype wire

// ---- hw/cim_pkg.sv ----
// Constants for the charger interrupt mask logic.
package cim_pkg;
   localparam logic [7:0] MASK_A_ADDR    = 8'h23;
   localparam logic [7:0] MASK_B_ADDR    = 8'h24;
   localparam logic [7:0] FAULT_MASK_ADDR = 8'h25;
   localparam logic [7:0] MASK_RESET_VAL = 8'h00;
   localparam logic [7:0] MASK_B_WRITABLE = 8'h09;
   localparam logic [7:0] FAULT_WRITABLE  = 8'hf9;
   localparam int         A_ADC_DONE   = 6;
   localparam int         A_THERM_REG  = 5;
   localparam int         A_SYS_MIN    = 4;
   localparam int         A_CUR_LOOP   = 3;
   localparam int         A_VOLT_LOOP  = 2;
   localparam int         A_TIMER      = 1;
   localparam int         A_WATCHDOG   = 0;
   localparam int         B_CHARGE     = 3;
   localparam int         B_SUPPLY     = 0;
   localparam int         F_SUPPLY     = 7;
   localparam int         F_BATTERY    = 6;
   localparam int         F_SYSTEM     = 5;
   localparam int         F_BOOST      = 4;
   localparam int         F_DIE_THERMAL_SHUTDOWN      = 3;
   localparam int         F_TZONE      = 0;
   localparam int         EVENT_COUNT  = 24;
   localparam int         PULSE_NS     = 1000;
   localparam int         CLK_NS       = 10;
   localparam int         PULSE_CYCLES = PULSE_NS / CLK_NS;
   localparam logic [7:0] PULSE_LEN    = 8'(PULSE_CYCLES);
endpackage : cim_pkg

// ---- hw/cim_pulse_gen.sv ----
// Fixed-length active-low pulse generator.
`timescale 1ns/1ps
`default_nettype none
module cim_pulse_gen (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic trigger,
   output logic      pulseN
);
   logic [7:0] count_q;

   // A trigger during a pulse restarts it.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_q <= 8'h00;
      end else if (trigger) begin
         count_q <= cim_pkg::PULSE_LEN;
      end else if (count_q != 8'h00) begin
         count_q <= count_q - 8'h01;
      end
   end

   assign pulseN = (count_q == 8'h00);
endmodule : cim_pulse_gen
`default_nettype wire

// ---- test/charger_interrupt_mask_logic_tb.sv ----
// Self-checking bench for the charger interrupt mask logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module charger_interrupt_mask_logic_tb;
   logic core_clk = 1'b0, reset = 1'b1, regResetCmd = 1'b0, regWrite = 1'b0, adcOneShot = 1'b1;
   logic flagClear = 1'b0, pulseDone, intN;
   logic [7:0] regAddr = 8'h0, regWdata = 8'h0, regRdata, flagA, flagB, flagF;
   logic [14:0] lv = 15'h0;
   logic [2:0] chg = 3'h0, sup = 3'h0, tz = 3'h0;
   logic [15:0] pulseLen, expLen;
   logic [15:0] expQ[$];
   int fails = 0, nTests = 0, seedDummy;
   int evReg[18] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 2, 2, 2, 2, 1, 1, 2};
   int evBit[18] = '{6, 5, 4, 3, 3, 3, 2, 2, 1, 0, 7, 6, 5, 4, 3, 3, 0, 0};
   localparam logic [15:0] PL = 16'(cim_pkg::PULSE_CYCLES);
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   cim_mask_logic u_dut (.core_clk(core_clk), .reset(reset), .regResetCmd(regResetCmd),
      .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .adcOneShot(adcOneShot), .adcConvDone(lv[0]), .die_thermal_regulation(lv[1]),
      .system_voltage_floor(lv[2]), .input_current_regulation(lv[3]),
      .external_current_limit_pin(lv[4]), .boost_current_regulation(lv[5]),
      .input_voltage_regulation(lv[6]), .boost_voltage_regulation(lv[7]),
      .safetyTimerExpired(lv[8]), .watchdogExpired(lv[9]), .chargeStatus(chg),
      .supplyStatus(sup), .supplyFault(lv[10]), .batteryFault(lv[11]), .systemFault(lv[12]),
      .boostFault(lv[13]), .die_thermal_shutdown(lv[14]), .tempZone(tz), .flagClear(flagClear),
      .chargerFlagA(flagA), .chargerFlagB(flagB), .faultFlag(flagF), .intN(intN));
   cim_host_model u_host (.core_clk(core_clk), .reset(reset), .intN(intN),
      .pulseDone(pulseDone), .pulseLen(pulseLen));
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regWrite = 1'b1;
      regAddr  = a;
      regWdata = d;
      @(negedge core_clk);
      regWrite = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      regAddr = a;
      @(negedge core_clk);
      `CHK(regRdata, e)
   endtask : rd
   task automatic fire(input int k, input logic up);
      @(negedge core_clk);
      if (k < 15) lv[k] = up;
      else if (up && k == 15) chg = chg ^ 3'(1 + $urandom % 7);
      else if (up && k == 16) sup = sup ^ 3'(1 + $urandom % 7);
      else if (up) tz = tz ^ 3'(1 + $urandom % 7);
   endtask : fire
   task automatic testEvent(input int k, input logic m);
      logic [7:0] bitv, wd;
      bitv = 8'h1 << evBit[k];
      wd = 8'($urandom);
      wd = m ? (wd | bitv) : (wd & ~bitv);
      wr(8'h23 + 8'(evReg[k]), wd);
      @(negedge core_clk);
      flagClear = 1'b1;
      @(negedge core_clk);
      flagClear = 1'b0;
      if (!m) expQ.push_back(PL);
      fire(k, 1'b1);
      repeat (130) @(negedge core_clk);
      `CHK({flagA, flagB, flagF}, 24'h1 << ((2 - evReg[k]) * 8 + evBit[k]))
      if (!m && k == 2) expQ.push_back(PL);
      fire(k, 1'b0);
      repeat (130) @(negedge core_clk);
      if (k < 8) `CHK(expQ.size(), 0)
      else if (k < 15) `CHK(expQ.size(), 0)
      else `CHK(expQ.size(), 0)
   endtask : testEvent
   always @(posedge core_clk) begin
      if (pulseDone === 1'b1) begin
         if (expQ.size() == 0) begin
            fails++;
            $display("BAD %0t unexpected interrupt pulse", $time);
         end else begin
            expLen = expQ.pop_front();
            `CHK(pulseLen, expLen)
         end
      end
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("BAD %0t run did not finish in time", $time);
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      seedDummy = $urandom(18);
      rd(8'h23, 8'h00);
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      for (int a = 8'h23; a <= 8'h26; a++) wr(8'(a), 8'hff);
      rd(8'h23, 8'hff);
      rd(8'h24, cim_pkg::MASK_B_WRITABLE);
      rd(8'h25, cim_pkg::FAULT_WRITABLE);
      rd(8'h26, 8'h00);
      @(negedge core_clk);
      regResetCmd = 1'b1;
      @(negedge core_clk);
      regResetCmd = 1'b0;
      rd(8'h23, 8'h00);
      adcOneShot = 1'b0;
      fire(0, 1'b1);
      repeat (130) @(negedge core_clk);
      `CHK({flagA, flagB, flagF}, 24'h0)
      fire(0, 1'b0);
      adcOneShot = 1'b1;
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 18; k++) testEvent(k, m[0]);
      end
      report_and_stop();
   end
endmodule : charger_interrupt_mask_logic_tb
`default_nettype wire

// ---- test/cim_host_model.sv ----
// Host side model that times every interrupt pulse it sees.
`timescale 1ns/1ps
`default_nettype none
module cim_host_model (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        intN,
   output logic             pulseDone,
   output logic      [15:0] pulseLen
);
   logic [15:0] count_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_q   <= 16'h0;
         pulseDone <= 1'b0;
         pulseLen  <= 16'h0;
      end else begin
         pulseDone <= 1'b0;
         if (intN == 1'b0) begin
            count_q <= count_q + 16'h1;
         end else if (count_q != 16'h0) begin
            pulseDone <= 1'b1;
            pulseLen  <= count_q;
            count_q   <= 16'h0;
         end
      end
   end
endmodule : cim_host_model
`default_nettype wire
